// file: rtl/hpw_pkg.sv
// Purpose: Shared constants for the host port wait-state engine.
// Assumes: One core clock (mclk, 100 MHz); host pins sampled synchronously.
// Notes:   Wait lengths are counted in sequencer cycles of two clocks each.
//
// Overview of operation
// - One sequencer cycle is two core clocks; all waits count them.
// - Instruction memory read holds ready low for 6 to 7 sequencer cycles.
// - Instruction memory write holds ready low for 5 to 7 cycles.
// - Data RAM read holds ready low for 9 to 33 sequencer cycles.
// - Data RAM write holds ready low for 9 to 29 sequencer cycles.
// - Too frequent data RAM access stretches the wait up to 97 cycles.
// - Memory read data is valid no later than ready rising.
// - Register read data follows the read strobe fall, no ready wait.
// - Data bus drives after read strobe falls, floats after it rises.
// - Ready is driven only while selected; pulled low after a memory strobe falls.

package hpw_pkg;

    // ------------------------------------------------------------------
    // Clocking and sequencer cycle
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;
    localparam int SEQ_CLKS = 2;
    localparam int SEQ_CYC_NS = SEQ_CLKS * MCLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Wait lengths in sequencer cycles
    // ------------------------------------------------------------------
    localparam int SEQ_CW = 7;
    localparam logic [6:0] IMEM_RD_MIN = 7'd6;
    localparam logic [6:0] IMEM_RD_MAX = 7'd7;
    localparam logic [6:0] IMEM_WR_MIN = 7'd5;
    localparam logic [6:0] IMEM_WR_MAX = 7'd7;
    localparam logic [6:0] DRAM_RD_MIN = 7'd9;
    localparam logic [6:0] DRAM_RD_MAX = 7'd33;
    localparam logic [6:0] DRAM_WR_MIN = 7'd9;
    localparam logic [6:0] DRAM_WR_MAX = 7'd29;
    localparam logic [6:0] DRAM_SLOW_MAX = 7'd97;
    localparam logic [6:0] LATE_DATA_SEQ = 7'd1;

    // ------------------------------------------------------------------
    // Address map of the host port
    // ------------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam logic [10:0] IMEM_BASE = 11'h200;
    localparam logic [10:0] DRAM_BASE = 11'h400;

    typedef enum logic [1:0] {TGT_REG, TGT_IMEM, TGT_DRAM} hpw_tgt_t;

endpackage : hpw_pkg

// file: rtl/hpw_seq_timer.sv
// Purpose: Counts sequencer cycles since the last clear, saturating.
// Assumes: A sequencer cycle is two clocks of mclk.
// Notes:   Used for access waits and for the data RAM overuse decay.

`timescale 1ns/100ps

module hpw_seq_timer
    import hpw_pkg::*;
#(
    parameter int CW = SEQ_CW
)
(
    input wire logic mclk,             // Core clock.
    input wire logic resetn,           // Asynchronous reset, active low.
    input wire logic clear,            // Restart counting from zero.
    output logic [CW-1:0] seq_count    // Whole sequencer cycles elapsed.
);

    logic [CW:0] clk_count_reg;

    if (CW < 2)
    begin : g_chk
        $error("hpw_seq_timer: CW too small");
    end

    // ------------------------------------------------------------------
    // Clock counter; the top bits give whole sequencer cycles.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            clk_count_reg <= '0;
        else if (clear)
            clk_count_reg <= '0;
        else if (clk_count_reg != '1)
            clk_count_reg <= clk_count_reg + 1'b1;
    end

    // Saturation keeps a stalled wait from wrapping back to short counts.
    assign seq_count = clk_count_reg[CW:1];

endmodule : hpw_seq_timer

// file: rtl/hpw_host_port.sv
// Purpose: Host processor port with ready wait states per access target.
// Assumes: Host pins synchronous to mclk; memories answer in the strobe cycle.
// Notes:   Supports multiplexed and separate address buses.

`timescale 1ns/100ps

module hpw_host_port
    import hpw_pkg::*;
#(
    parameter int OVERUSE_THRESH = 4,   // Data RAM accesses counted as overuse.
    parameter int DECAY_SEQ = 64        // Sequencer cycles per forgiven access.
)
(
    input wire logic mclk,                    // Core clock, 100 MHz.
    input wire logic resetn,                  // Asynchronous reset.
    input wire logic mux_mode,                // 1: multiplexed address/data.
    input wire logic sel_n,                   // Chip select, active low.
    input wire logic rd_n,                    // Read strobe, active low.
    input wire logic wr_n,                    // Write strobe, active low.
    input wire logic ale,                     // Address latch strobe.
    input wire logic [2:0] upper_addr_bits,   // High address, muxed mode.
    input wire logic [10:0] sep_addr,         // Address, separate bus mode.
    input wire logic [7:0] muxed_addr_data_i, // Data/address bus in.
    output logic [7:0] muxed_addr_data_o,     // Data bus out.
    output logic muxed_addr_data_oe,          // Data bus drive enable.
    output logic rdy_o,                       // Ready level, low = wait.
    output logic rdy_oe,                      // Ready drive enable.
    output logic [10:0] acc_addr,             // Address of current access.
    output logic reg_rd,                      // Register read strobe.
    output logic reg_wr,                      // Register write strobe.
    output logic [7:0] reg_wdata,             // Register write data.
    input wire logic [7:0] reg_rdata,         // Register read data.
    output logic mem_rd,                      // Memory read strobe.
    output logic mem_wr,                      // Memory write strobe.
    output logic mem_dram,                    // 1: data RAM, 0: instr memory.
    output logic [7:0] mem_wdata,             // Memory write data.
    input wire logic [7:0] mem_rdata,         // Memory data, valid with mem_rd.
    input wire logic seq_ram_free,            // Sequencer leaves RAM slot free.
    output logic throttle                     // Data RAM overuse detected.
);

    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_FETCH, ST_DONE, ST_LATE}
        hpw_state_t;

    hpw_state_t state_reg;
    hpw_tgt_t tgt_reg;
    logic is_rd_reg;
    logic rd_q_reg;
    logic wr_q_reg;
    logic ale_q_reg;
    logic [10:0] latch_addr_reg;
    logic [10:0] addr_reg;
    logic [7:0] dout_reg;
    logic reg_rd_reg;
    logic reg_wr_reg;
    logic [7:0] reg_wdata_reg;
    logic mem_wr_reg;
    logic [7:0] mem_wdata_reg;
    logic [7:0] recent_reg;
    logic rd_fall;
    logic wr_fall;
    logic strobe_rise;
    logic [10:0] cur_addr;
    hpw_tgt_t cur_tgt;
    logic timer_clear;
    logic [6:0] wait_cnt;
    logic [6:0] decay_cnt;
    logic decay_hit;
    logic release_now;
    logic [6:0] wait_min;
    logic [6:0] wait_lim;
    logic dram_start;

    if (OVERUSE_THRESH < 1 || OVERUSE_THRESH > 255
        || DECAY_SEQ < 1 || DECAY_SEQ > 127)
    begin : g_chk_param
        $error("hpw_host_port: OVERUSE_THRESH or DECAY_SEQ out of range");
    end

    // ------------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------------
    // Previous pin levels; pins are synchronous so no extra stages.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_q_reg <= 1'b1;
            wr_q_reg <= 1'b1;
            ale_q_reg <= 1'b0;
        end
        else
        begin
            rd_q_reg <= rd_n;
            wr_q_reg <= wr_n;
            ale_q_reg <= ale;
        end
    end

    assign rd_fall = rd_q_reg && !rd_n && !sel_n;
    assign wr_fall = wr_q_reg && !wr_n && !sel_n;
    assign strobe_rise = (!rd_q_reg && rd_n) || (!wr_q_reg && wr_n);

    // ------------------------------------------------------------------
    // Address capture and decode
    // ------------------------------------------------------------------
    // Multiplexed address is taken on the falling edge of the latch strobe.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            latch_addr_reg <= 11'h000;
        else if (ale_q_reg && !ale)
            latch_addr_reg <= {upper_addr_bits, muxed_addr_data_i};
    end

    assign cur_addr = mux_mode ? latch_addr_reg : sep_addr;

    // Decode by base address; everything below the memories is registers.
    always_comb
    begin
        if (cur_addr >= DRAM_BASE)
            cur_tgt = TGT_DRAM;
        else if (cur_addr >= IMEM_BASE)
            cur_tgt = TGT_IMEM;
        else
            cur_tgt = TGT_REG;
    end

    // ------------------------------------------------------------------
    // Wait timers
    // ------------------------------------------------------------------
    assign timer_clear = (state_reg == ST_IDLE) || (state_reg == ST_DONE);

    hpw_seq_timer #(.CW(SEQ_CW)) u_wait_timer (
        .mclk(mclk),
        .resetn(resetn),
        .clear(timer_clear),
        .seq_count(wait_cnt)
    );

    assign decay_hit = (decay_cnt >= 7'(DECAY_SEQ));

    hpw_seq_timer #(.CW(SEQ_CW)) u_decay_timer (
        .mclk(mclk),
        .resetn(resetn),
        .clear(decay_hit),
        .seq_count(decay_cnt)
    );

    // ------------------------------------------------------------------
    // Data RAM overuse detection
    // ------------------------------------------------------------------
    assign dram_start = (state_reg == ST_IDLE) && (rd_fall || wr_fall)
                        && (cur_tgt == TGT_DRAM);

    // Each access adds one, each decay period forgives one; a burst of
    // accesses faster than the decay rate climbs past the threshold.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            recent_reg <= 8'h00;
        else if (dram_start && !decay_hit && recent_reg != 8'hff)
            recent_reg <= recent_reg + 8'h01;
        else if (!dram_start && decay_hit && recent_reg != 8'h00)
            recent_reg <= recent_reg - 8'h01;
    end

    assign throttle = (recent_reg >= 8'(OVERUSE_THRESH));

    // ------------------------------------------------------------------
    // Release condition of the ready wait
    // ------------------------------------------------------------------
    // Reads leave one clock for the fetch, so the forced limit is one less.
    always_comb
    begin
        wait_min = 7'd0;
        wait_lim = 7'd1;
        unique case (tgt_reg)
            TGT_IMEM:
            begin
                wait_min = is_rd_reg ? IMEM_RD_MIN : IMEM_WR_MIN;
                wait_lim = is_rd_reg ? IMEM_RD_MAX : IMEM_WR_MAX;
            end
            TGT_DRAM:
            begin
                wait_min = is_rd_reg ? DRAM_RD_MIN : DRAM_WR_MIN;
                wait_lim = is_rd_reg ? DRAM_RD_MAX : DRAM_WR_MAX;
                // While overuse lasts the wait runs on to the stretched limit.
                if (throttle)
                    wait_lim = DRAM_SLOW_MAX;
                if (throttle)
                    wait_min = DRAM_SLOW_MAX - 7'd1;
            end
            default: ;
        endcase
    end

    // Data RAM waits end early only when the sequencer frees a slot.
    assign release_now = (wait_cnt >= wait_lim - 7'd1)
        || ((wait_cnt >= wait_min)
            && (seq_ram_free || tgt_reg != TGT_DRAM));

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            tgt_reg <= TGT_REG;
            is_rd_reg <= 1'b0;
            addr_reg <= 11'h000;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (rd_fall || wr_fall)
                    begin
                        addr_reg <= cur_addr;
                        tgt_reg <= cur_tgt;
                        is_rd_reg <= rd_fall;
                        // Registers answer at once with no wait state.
                        if (cur_tgt == TGT_REG)
                            state_reg <= ST_DONE;
                        else
                            state_reg <= ST_WAIT;
                    end
                ST_WAIT:
                    if (sel_n)
                        state_reg <= ST_IDLE;
                    else if (release_now)
                        state_reg <= is_rd_reg ? ST_FETCH : ST_DONE;
                ST_FETCH:
                    state_reg <= ST_DONE;
                ST_DONE:
                    if (strobe_rise || sel_n)
                    begin
                        if (!is_rd_reg && tgt_reg != TGT_REG && !sel_n)
                            state_reg <= ST_LATE;
                        else
                            state_reg <= ST_IDLE;
                    end
                ST_LATE:
                    if (wait_cnt >= LATE_DATA_SEQ)
                        state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register side strobes and data capture
    // ------------------------------------------------------------------
    // Register read strobe one clock after the read strobe falls.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            reg_rd_reg <= 1'b0;
        else
            reg_rd_reg <= (state_reg == ST_IDLE) && rd_fall
                          && (cur_tgt == TGT_REG);
    end

    // Write data is taken as the write strobe rises.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_wr_reg <= 1'b0;
            reg_wdata_reg <= 8'h00;
        end
        else
        begin
            reg_wr_reg <= 1'b0;
            if (state_reg == ST_DONE && !wr_q_reg && wr_n
                && tgt_reg == TGT_REG && !is_rd_reg)
            begin
                reg_wr_reg <= 1'b1;
                reg_wdata_reg <= muxed_addr_data_i;
            end
        end
    end

    // Memory writes commit one sequencer cycle after the strobe rises,
    // because the host may still be settling the data until then.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_wr_reg <= 1'b0;
            mem_wdata_reg <= 8'h00;
        end
        else
        begin
            mem_wr_reg <= 1'b0;
            if (state_reg == ST_LATE && wait_cnt >= LATE_DATA_SEQ)
            begin
                mem_wr_reg <= 1'b1;
                mem_wdata_reg <= muxed_addr_data_i;
            end
        end
    end

    // Read data register: registers a clock after their strobe, memories
    // in the fetch clock so data is settled when ready rises.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            dout_reg <= 8'h00;
        else if (reg_rd_reg)
            dout_reg <= reg_rdata;
        else if (state_reg == ST_FETCH)
            dout_reg <= mem_rdata;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign acc_addr = addr_reg;
    assign reg_rd = reg_rd_reg;
    assign reg_wr = reg_wr_reg;
    assign reg_wdata = reg_wdata_reg;
    assign mem_rd = (state_reg == ST_FETCH);
    assign mem_wr = mem_wr_reg;
    assign mem_dram = (tgt_reg == TGT_DRAM);
    assign mem_wdata = mem_wdata_reg;
    assign muxed_addr_data_o = dout_reg;

    // The bus is driven only while a selected read strobe is low.
    assign muxed_addr_data_oe = !sel_n && !rd_n;

    // Ready floats when deselected and is low only while a wait runs.
    assign rdy_oe = !sel_n;
    assign rdy_o = !((state_reg == ST_WAIT) || (state_reg == ST_FETCH));

endmodule : hpw_host_port

// file: testbench/hpw_host_port_assertions.sv
// Purpose: Port checks of the host port wait-state engine.
// Assumes: Waits counted in mclk clocks, two per sequencer cycle.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/100ps
module hpw_host_port_assertions
(
    input wire logic mclk,                    // Core clock.
    input wire logic resetn,                  // Reset, active low.
    input wire logic sel_n,                   // Chip select.
    input wire logic rd_n,                    // Read strobe.
    input wire logic wr_n,                    // Write strobe.
    input wire logic [7:0] muxed_addr_data_i, // Bus in.
    input wire logic [7:0] muxed_addr_data_o, // Bus out.
    input wire logic muxed_addr_data_oe,      // Bus enable.
    input wire logic rdy_o,                   // Ready level.
    input wire logic rdy_oe,                  // Ready enable.
    input wire logic reg_rd,                  // Register read.
    input wire logic reg_wr,                  // Register write.
    input wire logic [7:0] reg_rdata,         // Register data.
    input wire logic mem_rd,                  // Memory read.
    input wire logic mem_wr,                  // Memory write.
    input wire logic mem_dram,                // Data RAM target.
    input wire logic [7:0] mem_rdata,         // Memory data.
    input wire logic [7:0] mem_wdata,         // Memory write data.
    input wire logic throttle                 // Overuse flag.
);
    logic [7:0] low_cnt;
    logic thr_seen;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // -----------------------------------------------------------------
    // Wait length helper
    // -----------------------------------------------------------------
    // Overuse seen during a wait voids the normal limits for that wait.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_cnt <= 8'h00;
            thr_seen <= 1'b0;
        end
        else
        begin
            low_cnt <= rdy_o ? 8'h00 : low_cnt + 8'h01;
            thr_seen <= throttle | (thr_seen & !rdy_o);
        end
    end

    sequence s_end_rd;
        $rose(rdy_o) ##0 !rd_n;
    endsequence
    sequence s_end_wr;
        $rose(rdy_o) ##0 !wr_n;
    endsequence

    chk_rdy_float: assert property (rdy_oe == !sel_n)
        else $error("ready enable does not follow select");
    chk_rdy_cause: assert property ($fell(rdy_o) |->
        !sel_n && (!$past(rd_n) || !$past(wr_n)))
        else $error("ready fell without a strobe");
    chk_bus_drive: assert property (
        muxed_addr_data_oe == (!sel_n && !rd_n))
        else $error("bus drive not tied to read strobe");
    chk_reg_nowait: assert property (
        (reg_rd || reg_wr) |-> rdy_o ##1 rdy_o)
        else $error("register access waited");
    chk_reg_data: assert property (
        reg_rd |=> muxed_addr_data_o == $past(reg_rdata))
        else $error("register read data wrong");
    chk_mem_data: assert property (mem_rd |=> rdy_o &&
        muxed_addr_data_o == $past(mem_rdata))
        else $error("memory data not valid at ready");
    chk_imem_rd: assert property (s_end_rd ##0 !mem_dram |->
        low_cnt >= 8'd12 && low_cnt <= 8'd14)
        else $error("instruction read wait out of range");
    chk_imem_wr: assert property (s_end_wr ##0 !mem_dram |->
        low_cnt >= 8'd10 && low_cnt <= 8'd14)
        else $error("instruction write wait out of range");
    chk_dram_rd: assert property (s_end_rd ##0
        (mem_dram && !thr_seen) |-> low_cnt >= 8'd18 && low_cnt <= 8'd66)
        else $error("data RAM read wait out of range");
    chk_dram_wr: assert property (s_end_wr ##0
        (mem_dram && !thr_seen) |-> low_cnt >= 8'd18 && low_cnt <= 8'd58)
        else $error("data RAM write wait out of range");
    chk_dram_cap: assert property ($rose(rdy_o) ##0 mem_dram |->
        low_cnt >= 8'd18 && low_cnt <= 8'd194)
        else $error("data RAM wait beyond the stretch limit");
    chk_late_data: assert property (mem_wr |-> $past(wr_n) &&
        mem_wdata == $past(muxed_addr_data_i))
        else $error("memory write data not taken late");
endmodule : hpw_host_port_assertions

// file: testbench/hpw_host_model.sv
// Purpose: Behavioural host processor driving the host port pins.
// Assumes: Pins change 1 ns after a rising edge of mclk.
// Notes:   Released pins show the inverse of their last value.
`timescale 1ns/100ps
module hpw_host_model
    import hpw_pkg::*;
(
    input wire logic mclk,              // Core clock.
    input wire logic mux_mode,          // Bus style in use.
    input wire logic rdy_o,             // Ready from the device.
    input wire logic [7:0] rdata,       // Read data from the device.
    output logic sel_n,                 // Chip select.
    output logic rd_n,                  // Read strobe.
    output logic wr_n,                  // Write strobe.
    output logic ale,                   // Address latch strobe.
    output logic [2:0] upper_addr_bits, // High address.
    output logic [10:0] sep_addr,       // Separate address.
    output logic [7:0] bus              // Shared bus.
);
    // Idle pins at time zero.
    initial
    begin
        {sel_n, rd_n, wr_n, ale} = 4'he;
        upper_addr_bits = 3'h0;
        sep_addr = 11'h000;
        bus = 8'h00;
    end

    // One access; memory write data arrives a clock after the strobe rise.
    task automatic access(input logic wr, input logic [10:0] a,
        input logic [7:0] wd, output int w, output logic [7:0] rd);
        int n;
        w = 0;
        n = 0;
        @(posedge mclk);
        #1;
        sel_n = 1'b0;
        ale = mux_mode;
        upper_addr_bits = a[10:8];
        sep_addr = a;
        bus = mux_mode ? a[7:0] : ~wd;
        @(posedge mclk);
        #1;
        ale = 1'b0;
        @(posedge mclk);
        #1;
        bus = (a < IMEM_BASE) ? wd : ~wd;
        rd_n = wr;
        wr_n = !wr;
        do
        begin
            @(posedge mclk);
            n++;
            w += !rdy_o;
        end
        while ((n < 4 || !rdy_o) && n < 400);
        rd = rdata;
        #1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(posedge mclk);
        #1;
        bus = wd;
        repeat (3) @(posedge mclk);
        #1;
        sel_n = 1'b1;
        bus = ~bus;
        upper_addr_bits = ~upper_addr_bits;
        sep_addr = ~sep_addr;
        repeat (3) @(posedge mclk);
    endtask : access
endmodule : hpw_host_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench of the host port wait-state engine.
// Assumes: Fixed seed; waits measured by the host model in clocks.
// Notes:   Long idles keep normal accesses clear of overuse.
`timescale 1ns/100ps
module testbench
    import hpw_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic mux_mode = 1'b0;
    logic free_hold = 1'b0;
    logic seq_ram_free = 1'b1;
    wire logic sel_n, rd_n, wr_n, ale, muxed_addr_data_oe, rdy_o, rdy_oe;
    wire logic reg_rd, reg_wr, mem_rd, mem_wr, mem_dram, throttle;
    wire logic [2:0] upper_addr_bits;
    wire logic [10:0] sep_addr, acc_addr;
    wire logic [7:0] muxed_addr_data_i, muxed_addr_data_o, reg_wdata;
    wire logic [7:0] mem_wdata, reg_rdata, mem_rdata;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int wmax;
    logic [10:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_dram;
    logic thr_any;

    function automatic logic [7:0] exp_data(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h15};
    endfunction : exp_data

    // Memories answer only in their strobe cycle, garbage otherwise.
    assign reg_rdata = reg_rd ? exp_data(acc_addr) : ~exp_data(acc_addr);
    assign mem_rdata = mem_rd ? exp_data(acc_addr) : ~exp_data(acc_addr);

    always #5 mclk = ~mclk;

    // Sequencer slot freedom is random unless held busy.
    always @(posedge mclk)
        #1 seq_ram_free <= free_hold ? 1'b0 : 1'($urandom);

    hpw_host_port #(.OVERUSE_THRESH(2), .DECAY_SEQ(64)) dut_u (.mclk,
        .resetn, .mux_mode, .sel_n, .rd_n, .wr_n, .ale, .upper_addr_bits,
        .sep_addr, .muxed_addr_data_i, .muxed_addr_data_o,
        .muxed_addr_data_oe, .rdy_o, .rdy_oe, .acc_addr, .reg_rd, .reg_wr,
        .reg_wdata, .reg_rdata, .mem_rd, .mem_wr, .mem_dram, .mem_wdata,
        .mem_rdata, .seq_ram_free, .throttle);

    hpw_host_model host_u (.mclk, .mux_mode, .rdy_o,
        .rdata(muxed_addr_data_o), .sel_n, .rd_n, .wr_n, .ale,
        .upper_addr_bits, .sep_addr, .bus(muxed_addr_data_i));

    task automatic conclude();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Wait limit in clocks for a target, from sequencer cycle counts.
    function automatic int lim(input logic [10:0] a, input logic wr,
        input logic hi);
        logic [6:0] s;
        if (a < IMEM_BASE)
            s = 7'd0;
        else if (a < DRAM_BASE)
            s = wr ? (hi ? IMEM_WR_MAX : IMEM_WR_MIN)
                   : (hi ? IMEM_RD_MAX : IMEM_RD_MIN);
        else
            s = wr ? (hi ? DRAM_WR_MAX : DRAM_WR_MIN)
                   : (hi ? DRAM_RD_MAX : DRAM_RD_MIN);
        return int'(s) * SEQ_CLKS;
    endfunction : lim

    // Cycle count, timeout and capture of the write strobes.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles > 30000)
        begin
            n_errors++;
            $display("BAD %0t run did not finish", $time);
            conclude();
        end
        if (reg_wr === 1'b1)
            {wr_dram, wr_addr, wr_data} = {1'b0, acc_addr, reg_wdata};
        if (mem_wr === 1'b1)
            {wr_dram, wr_addr, wr_data} = {mem_dram, acc_addr, mem_wdata};
        if (throttle === 1'b1)
            thr_any = 1'b1;
    end

    // One access with its checks; thr widens the limit to the stretch.
    task automatic do_acc(input logic wr, input logic [10:0] a,
        input logic thr, output int w);
        logic [7:0] d, rd;
        int hi;
        d = 8'($urandom);
        wr_addr = ~a;
        wr_data = ~d;
        hi = thr ? int'(DRAM_SLOW_MAX) * SEQ_CLKS : lim(a, wr, 1'b1);
        host_u.access(wr, a, d, w, rd);
        #1;
        check(16'(w >= lim(a, wr, 1'b0) && w <= hi), 16'h1);
        check({14'h0, rdy_oe, muxed_addr_data_oe}, 16'h0);
        if (!wr)
            check(16'(rd), 16'(exp_data(a)));
        else
        begin
            check(16'(wr_addr), 16'(a));
            check(16'(wr_data), 16'(d));
            check(16'(wr_dram), 16'(a >= DRAM_BASE));
        end
    endtask : do_acc

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    // Corners and random accesses in both bus styles, then overuse.
    initial
    begin
        logic [10:0] corner [6];
        int w;
        corner = '{11'h000, 11'h1ff, 11'h200, 11'h3ff, 11'h400, 11'h7ff};
        void'($urandom(32'h0e164c74));
        idle(4);
        resetn = 1'b1;
        idle(2);
        for (int m = 0; m < 2; m++)
        begin
            mux_mode = m[0];
            for (int i = 0; i < 12; i++)
            begin
                do_acc(i[0], corner[i / 2], 1'b0, w);
                idle(150);
                do_acc(1'($urandom), 11'($urandom), 1'b0, w);
                idle(150);
            end
        end
        free_hold = 1'b1;
        do_acc(1'b0, 11'h5a5, 1'b0, w);
        idle(150);
        do_acc(1'b1, 11'h6c3, 1'b0, w);
        idle(150);
        free_hold = 1'b0;
        wmax = 0;
        thr_any = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            do_acc(i[0], 11'h400 + 11'(i), 1'b1, w);
            wmax = (w > wmax) ? w : wmax;
        end
        check(16'(thr_any), 16'h1);
        check(16'(wmax > lim(11'h400, 1'b0, 1'b1)), 16'h1);
        idle(1200);
        check(16'(throttle), 16'h0);
        do_acc(1'b0, 11'h455, 1'b0, w);
        conclude();
    end
endmodule : testbench

bind hpw_host_port hpw_host_port_assertions chk_u (.mclk, .resetn, .sel_n,
    .rd_n, .wr_n, .muxed_addr_data_i, .muxed_addr_data_o,
    .muxed_addr_data_oe, .rdy_o, .rdy_oe, .reg_rd, .reg_wr, .reg_rdata,
    .mem_rd, .mem_wr, .mem_dram, .mem_rdata, .mem_wdata, .throttle);
